// *** verilog/spd_sfr_decode.sv ***
// sfr space decode with sfr paging and the xram page register
`timescale 1ns/10ps
`default_nettype none
`include "spd_consts.svh"

module spd_sfr_decode (
	// clock and reset
	input wire logic CLK,
	input wire logic RESET,
	// access request from the core
	input wire logic REQ_VALID,
	input wire spd_pkg::spd_kind_t REQ_KIND,
	input wire logic REQ_WRITE,
	input wire logic REQ_BIT,
	input wire logic [2:0] REQ_BIT_POS,
	input wire logic [7:0] REQ_ADDR,
	input wire logic [7:0] REQ_WDATA,
	input wire logic REQ_IDX_SEL,
	input wire logic [7:0] REQ_R0,
	input wire logic [7:0] REQ_R1,
	input wire logic [15:0] REQ_DPTR,
	// decoded answer
	output logic RSP_VALID,
	output spd_pkg::spd_target_t RSP_TARGET,
	output logic [15:0] RSP_ADDR,
	output logic RSP_PAGE_F,
	output logic RSP_SHARED,
	output logic RSP_RESERVED,
	output logic RSP_BIT_REFUSED,
	output logic RSP_LOCAL,
	output logic [7:0] RSP_RDATA,
	// register state
	output logic [7:0] SFR_PAGE,
	output logic XRAM_PAGE_BIT
);
	import spd_pkg::*;

	logic [7:0] page_q;
	logic [7:0] page_d;
	logic xpg_q;
	logic xpg_d;

	logic rsp_valid_q;
	spd_target_t rsp_target_q;
	spd_target_t rsp_target_d;
	logic [15:0] rsp_addr_q;
	logic [15:0] rsp_addr_d;
	logic rsp_page_f_q;
	logic rsp_shared_q;
	logic rsp_reserved_q;
	logic rsp_bit_refused_q;
	logic rsp_local_q;
	logic [7:0] rsp_rdata_q;
	logic [7:0] rsp_rdata_d;
	// next values of the answer flops
	logic rsp_valid_d;
	logic rsp_page_f_d;
	logic rsp_shared_d;
	logic rsp_reserved_d;
	logic rsp_bit_refused_d;
	logic rsp_local_d;

	// request class
	wire logic is_direct = (REQ_KIND == SPD_KIND_DIRECT);
	wire logic is_indirect = (REQ_KIND == SPD_KIND_INDIRECT);
	wire logic is_movx8 = (REQ_KIND == SPD_KIND_MOVX8);
	wire logic is_movx16 = (REQ_KIND == SPD_KIND_MOVX16);
	wire logic upper_half = REQ_ADDR[`SPD_SFR_BASE_BIT];

	// only the second page value switches the map; every other value acts as page zero
	wire logic page_f = (page_q == `SPD_PAGE_SECOND);

	spd_map_if map_if();
	assign map_if.addr = REQ_ADDR;
	assign map_if.page_f = page_f;

	spd_page_map u_map (
		.m(map_if.map)
	);

	// effective external address of both move forms
	logic [15:0] xaddr;

	spd_xaddr u_xaddr (
		.movx8(is_movx8),
		.idx_sel(REQ_IDX_SEL),
		.r0(REQ_R0),
		.r1(REQ_R1),
		.dptr(REQ_DPTR),
		.page_bit(xpg_q),
		.addr(xaddr)
	);

	// steering
	wire logic sfr_hit = REQ_VALID & is_direct & upper_half;
	wire logic iram_hit = REQ_VALID & ((is_direct & ~upper_half) | is_indirect);
	wire logic xram_hit = REQ_VALID & (is_movx8 | is_movx16);

	// bit access only in the 0/8 columns; refused ones change nothing
	wire logic bit_refused = sfr_hit & REQ_BIT & ~map_if.bit_ok;
	// reserved holes are flagged only; nothing here acts on them
	wire logic reserved = sfr_hit & ~map_if.occupied;

	// local registers
	wire logic hit_page = sfr_hit & (REQ_ADDR == `SPD_ADDR_SFR_PAGE);
	wire logic hit_xpg = sfr_hit & ~page_f & (REQ_ADDR == `SPD_ADDR_XRAM_PAGE);
	wire logic hit_local = hit_page | hit_xpg;

	// both local addresses end in 7 or A, so no bit write can reach them
	wire logic local_wr = REQ_WRITE & ~REQ_BIT;
	wire logic page_wr = hit_page & local_wr;
	wire logic xpg_wr = hit_xpg & local_wr;

	always_comb begin
		page_d = page_q;
		if (page_wr) begin
			page_d = REQ_WDATA;
		end
	end

	always_comb begin
		xpg_d = xpg_q;
		if (xpg_wr) begin
			xpg_d = REQ_WDATA[`SPD_XPG_BIT];
		end
	end

	// read data of the local registers; upper bits of the xram page byte are constant zero
	wire logic [7:0] xpg_rd = {`SPD_XRAM_PAGE_UNUSED, xpg_q};
	wire logic [7:0] byte_rd = hit_page ? page_q : (hit_xpg ? xpg_rd : 8'h00);
	wire logic local_rd = hit_local & ~REQ_WRITE;

	// local read returns the register byte, everything else reads zero
	always_comb begin
		rsp_rdata_d = 8'h00;
		if (local_rd) begin
			rsp_rdata_d = byte_rd;
		end
	end

	// internal spaces only ever use the low address byte
	wire logic [15:0] near_addr = {8'h00, REQ_ADDR};

	// first match wins; the request kinds never overlap
	always_comb begin
		rsp_target_d = SPD_TGT_NONE;
		if (sfr_hit) begin
			rsp_target_d = SPD_TGT_SFR;
		end else if (iram_hit) begin
			rsp_target_d = SPD_TGT_IRAM;
		end else if (xram_hit) begin
			rsp_target_d = SPD_TGT_XRAM;
		end
	end

	always_comb begin
		rsp_addr_d = 16'h0000;
		if (sfr_hit || iram_hit) begin
			rsp_addr_d = near_addr;
		end else if (xram_hit) begin
			rsp_addr_d = xaddr;
		end
	end

	// next answer flags, all qualified by the request of this cycle
	assign rsp_valid_d = REQ_VALID;
	assign rsp_page_f_d = sfr_hit & page_f;
	assign rsp_shared_d = sfr_hit & map_if.shared;
	assign rsp_reserved_d = reserved;
	assign rsp_bit_refused_d = bit_refused;
	assign rsp_local_d = hit_local;

	// registers of this block
	// a page write lands on this edge, so the next request decodes on the new page
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			page_q <= `SPD_SFR_PAGE_RESET;
		end else begin
			page_q <= page_d;
		end
	end

	// only the select bit is stored; the other seven read back as zero
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			xpg_q <= `SPD_XRAM_PAGE_RESET;
		end else begin
			xpg_q <= xpg_d;
		end
	end

	// answer, one cycle after the request; one flop per block keeps each block short
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			rsp_valid_q <= 1'b0;
		end else begin
			rsp_valid_q <= rsp_valid_d;
		end
	end

	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			rsp_target_q <= SPD_TGT_NONE;
		end else begin
			rsp_target_q <= rsp_target_d;
		end
	end

	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			rsp_addr_q <= 16'h0000;
		end else begin
			rsp_addr_q <= rsp_addr_d;
		end
	end

	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			rsp_page_f_q <= 1'b0;
		end else begin
			rsp_page_f_q <= rsp_page_f_d;
		end
	end

	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			rsp_shared_q <= 1'b0;
		end else begin
			rsp_shared_q <= rsp_shared_d;
		end
	end

	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			rsp_reserved_q <= 1'b0;
		end else begin
			rsp_reserved_q <= rsp_reserved_d;
		end
	end

	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			rsp_bit_refused_q <= 1'b0;
		end else begin
			rsp_bit_refused_q <= rsp_bit_refused_d;
		end
	end

	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			rsp_local_q <= 1'b0;
		end else begin
			rsp_local_q <= rsp_local_d;
		end
	end

	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			rsp_rdata_q <= 8'h00;
		end else begin
			rsp_rdata_q <= rsp_rdata_d;
		end
	end

	// every answer port comes straight from a flop
	assign RSP_VALID = rsp_valid_q;
	assign RSP_TARGET = rsp_target_q;
	assign RSP_ADDR = rsp_addr_q;
	assign RSP_PAGE_F = rsp_page_f_q;
	assign RSP_SHARED = rsp_shared_q;
	assign RSP_RESERVED = rsp_reserved_q;
	assign RSP_BIT_REFUSED = rsp_bit_refused_q;
	assign RSP_LOCAL = rsp_local_q;
	assign RSP_RDATA = rsp_rdata_q;
	assign SFR_PAGE = page_q;
	assign XRAM_PAGE_BIT = xpg_q;

	// bit position belongs to the peripheral that owns the addressed byte
	wire logic unused_bit_pos = ^REQ_BIT_POS;
endmodule

`default_nettype wire

// *** verilog/spd_consts.svh ***
// constants for the sfr space and paging decoder
// Behaviour
// - The xram page register reads zero in bits 7 to 1, ignores writes there, and only bit 0 holds state, reset to zero.
// - An 8-bit indirect external move takes its upper address byte from the xram page register.
// - With the page bit set, 8-bit indirect external moves reach 0x0100-0x01FF, otherwise 0x0000-0x00FF.
// - The xram page register decodes at direct address 0xAA while any sfr page value other than 0x0F is selected.
// - Direct accesses from 0x80 to 0xFF go to the sfr space, not to internal ram.
// - Sfr addresses ending in 0x0 or 0x8 accept bit access, all other sfr addresses byte access only.
// - After reset and while the page register holds its default, sfr accesses target page 0x0.
// - With page 0x0F selected, direct addresses map onto the second register set.
// - The shared registers, the page register among them, decode the same on both pages.
// - The page register is an 8-bit read/write register at 0xA7 on every page, reset to zero.
// - Indirect accesses above 0x7F reach upper internal ram, never the sfrs.
// - In the 8-bit indirect external move the low address byte comes from R0 or as named.
`ifndef SPD_CONSTS_SVH
`define SPD_CONSTS_SVH

`define SPD_ADDR_SFR_PAGE 8'hA7
`define SPD_ADDR_XRAM_PAGE 8'hAA
`define SPD_SFR_PAGE_RESET 8'h00
`define SPD_XRAM_PAGE_RESET 1'b0
`define SPD_PAGE_DEFAULT 8'h00
`define SPD_PAGE_SECOND 8'h0F
`define SPD_XPG_BIT 0
`define SPD_SFR_BASE_BIT 7
`define SPD_BIT_COL_MASK 3'h7
`define SPD_XRAM_PAGE_UNUSED 7'h00

`endif

// *** verilog/spd_pkg.sv ***
// types shared by the sfr space and paging decoder
package spd_pkg;

	typedef enum logic [1:0] {
		SPD_KIND_DIRECT = 2'h0,
		SPD_KIND_INDIRECT = 2'h1,
		SPD_KIND_MOVX8 = 2'h3,
		SPD_KIND_MOVX16 = 2'h2
	} spd_kind_t;

	typedef enum logic [1:0] {
		SPD_TGT_NONE = 2'h0,
		SPD_TGT_IRAM = 2'h1,
		SPD_TGT_SFR = 2'h3,
		SPD_TGT_XRAM = 2'h2
	} spd_target_t;

endpackage

// *** verilog/spd_map_if.sv ***
// lookup signals between the decoder and its sfr page map
`timescale 1ns/10ps
`default_nettype none

interface spd_map_if;
	logic [7:0] addr;
	logic page_f;
	logic occupied;
	logic shared;
	logic bit_ok;

	modport map (
		input addr,
		input page_f,
		output occupied,
		output shared,
		output bit_ok
	);

	modport user (
		output addr,
		output page_f,
		input occupied,
		input shared,
		input bit_ok
	);
endinterface

`default_nettype wire

// *** verilog/spd_page_map.sv ***
// occupancy and bit-access lookup of the two sfr pages
`timescale 1ns/10ps
`default_nettype none
`include "spd_consts.svh"

module spd_page_map (
	spd_map_if.map m
);
	// holes in the page-zero map
	function automatic logic occ_page0(input logic [7:0] a);
		case (a)
			8'hAB, 8'hAF, 8'hB4, 8'hD6, 8'hF3: occ_page0 = 1'b0;
			default: occ_page0 = 1'b1;
		endcase
	endfunction

	// registers visible the same on both pages
	function automatic logic is_shared(input logic [7:0] a);
		case (a)
			8'h80, 8'h81, 8'h82, 8'h83, 8'h87, 8'h90, 8'hA0, 8'hA7, 8'hA8, 8'hA9,
			8'hD0, 8'hE0, 8'hE5, 8'hE6, 8'hE7, 8'hF0, 8'hF6, 8'hF7: is_shared = 1'b1;
			default: is_shared = 1'b0;
		endcase
	endfunction

	// second register set only
	function automatic logic only_f(input logic [7:0] a);
		case (a)
			8'h85, 8'h86, 8'h91, 8'h92, 8'h93, 8'h94, 8'h95, 8'h96, 8'h97,
			8'hA4, 8'hA5, 8'hA6, 8'hB5, 8'hB9, 8'hBA, 8'hBD: only_f = 1'b1;
			default: only_f = 1'b0;
		endcase
	endfunction

	wire logic shared_w = is_shared(m.addr);
	wire logic occ_f = shared_w | only_f(m.addr);

	assign m.shared = shared_w;
	assign m.occupied = m.page_f ? occ_f : occ_page0(m.addr);
	assign m.bit_ok = (m.addr[2:0] == 3'h0);
endmodule

`default_nettype wire

// *** verilog/spd_xaddr.sv ***
// effective external address of the two external move forms
`timescale 1ns/10ps
`default_nettype none
`include "spd_consts.svh"

module spd_xaddr (
	// request
	input wire logic movx8,
	input wire logic idx_sel,
	input wire logic [7:0] r0,
	input wire logic [7:0] r1,
	input wire logic [15:0] dptr,
	// page register bit
	input wire logic page_bit,
	// result
	output logic [15:0] addr
);
	wire logic [7:0] low_byte = idx_sel ? r1 : r0;
	wire logic [7:0] high_byte = {`SPD_XRAM_PAGE_UNUSED, page_bit};

	// data pointer form ignores the page register entirely
	assign addr = movx8 ? {high_byte, low_byte} : dptr;
endmodule

`default_nettype wire

// *** dv/spd_sfr_decode_sva.sv ***
// concurrent checks on the decoder ports
`timescale 1ns/10ps
`default_nettype none
module spd_sfr_decode_sva (
	// clock and reset
	input wire logic CLK,
	input wire logic RESET,
	// request
	input wire logic REQ_VALID,
	input wire spd_pkg::spd_kind_t REQ_KIND,
	input wire logic REQ_WRITE,
	input wire logic REQ_BIT,
	input wire logic [7:0] REQ_ADDR,
	input wire logic [7:0] REQ_WDATA,
	input wire logic REQ_IDX_SEL,
	input wire logic [7:0] REQ_R0,
	input wire logic [7:0] REQ_R1,
	input wire logic [15:0] REQ_DPTR,
	// answer and state
	input wire spd_pkg::spd_target_t RSP_TARGET,
	input wire logic [15:0] RSP_ADDR,
	input wire logic RSP_PAGE_F,
	input wire logic RSP_BIT_REFUSED,
	input wire logic RSP_LOCAL,
	input wire logic [7:0] SFR_PAGE,
	input wire logic XRAM_PAGE_BIT
);
	import spd_pkg::*;
	default clocking @(posedge CLK);
	endclocking
	default disable iff (RESET);
	sequence s_sfr;
		REQ_VALID && REQ_KIND == SPD_KIND_DIRECT && REQ_ADDR[7];
	endsequence
	sequence s_byte_wr(a);
		s_sfr ##0 (REQ_WRITE && !REQ_BIT && REQ_ADDR == a);
	endsequence
	AST_DIRECT_SFR: assert property (s_sfr |=> RSP_TARGET == SPD_TGT_SFR)
		else $error("direct access missed sfr space");
	AST_INDIRECT_IRAM: assert property (REQ_VALID && REQ_KIND == SPD_KIND_INDIRECT
		|=> RSP_TARGET == SPD_TGT_IRAM && RSP_ADDR == {8'h00, $past(REQ_ADDR)})
		else $error("indirect access missed internal ram");
	AST_MOVX8_ADDR: assert property (REQ_VALID && REQ_KIND == SPD_KIND_MOVX8 |=>
		RSP_ADDR == {7'h00, $past(XRAM_PAGE_BIT), ($past(REQ_IDX_SEL) ? $past(REQ_R1) : $past(REQ_R0))})
		else $error("short external address wrong");
	AST_MOVX16_ADDR: assert property (REQ_VALID && REQ_KIND == SPD_KIND_MOVX16
		|=> RSP_TARGET == SPD_TGT_XRAM && RSP_ADDR == $past(REQ_DPTR))
		else $error("pointer external address wrong");
	AST_XPAGE_WRITE: assert property (s_byte_wr(8'hAA) ##0 SFR_PAGE != 8'h0F
		|=> RSP_LOCAL && XRAM_PAGE_BIT == $past(REQ_WDATA[0]))
		else $error("xram page bit not written");
	AST_XPAGE_HIDDEN: assert property (s_byte_wr(8'hAA) ##0 SFR_PAGE == 8'h0F
		|=> !RSP_LOCAL && $stable(XRAM_PAGE_BIT))
		else $error("xram page reached on second page");
	AST_PAGE_WRITE: assert property (s_byte_wr(8'hA7)
		|=> RSP_LOCAL && SFR_PAGE == $past(REQ_WDATA))
		else $error("page register not written");
	AST_BIT_COLUMN: assert property (s_sfr ##0 REQ_BIT
		|=> RSP_BIT_REFUSED == ($past(REQ_ADDR[2:0]) != 3'h0))
		else $error("bit access decision wrong");
	AST_PAGE_SELECT: assert property (s_sfr
		|=> RSP_PAGE_F == ($past(SFR_PAGE) == 8'h0F))
		else $error("page choice wrong");
endmodule
bind spd_sfr_decode spd_sfr_decode_sva u_sva (.CLK, .RESET, .REQ_VALID, .REQ_KIND, .REQ_WRITE,
	.REQ_BIT, .REQ_ADDR, .REQ_WDATA, .REQ_IDX_SEL, .REQ_R0, .REQ_R1, .REQ_DPTR, .RSP_TARGET,
	.RSP_ADDR, .RSP_PAGE_F, .RSP_BIT_REFUSED, .RSP_LOCAL, .SFR_PAGE, .XRAM_PAGE_BIT);
`default_nettype wire

// *** dv/spd_core_model.sv ***
// behavioural core issuing accesses to the decoder
`timescale 1ns/10ps
`default_nettype none
module spd_core_model (
	// clock
	input wire logic clk,
	// request
	output logic valid,
	output spd_pkg::spd_kind_t kind,
	output logic wr,
	output logic bt,
	output logic [7:0] addr,
	output logic [7:0] wdata,
	output logic idx,
	output logic [7:0] r0,
	output logic [7:0] r1,
	output logic [15:0] dptr
);
	import spd_pkg::*;
	initial begin
		valid = 1'b0;
		kind = SPD_KIND_DIRECT;
		{wr, bt, idx, addr, wdata, r0, r1, dptr} = '0;
	end
	// call at a falling edge; answer stands on return; callers avoid reserved sfrs except 0xAA on page 0x0F
	task automatic issue(input spd_kind_t k, input logic w, input logic b, input logic [7:0] a,
		input logic [7:0] d);
		valid = 1'b1;
		kind = k;
		wr = w;
		bt = b;
		addr = a;
		wdata = d;
		@(negedge clk);
	endtask
	task automatic regs(input logic i, input logic [7:0] x0, input logic [7:0] x1);
		idx = i;
		r0 = x0;
		r1 = x1;
		dptr = 16'h1234;
	endtask
	// released address and write data lines flip so a stale value never passes for live
	task automatic stop();
		valid = 1'b0;
		addr = ~addr;
		wdata = ~wdata;
		@(negedge clk);
	endtask
endmodule
`default_nettype wire

// *** dv/tb.sv ***
// self-checking bench for the sfr paging decoder
`timescale 1ns/10ps
`default_nettype none
module tb;
	import spd_pkg::*;
	logic clk = 1'b0;
	logic reset = 1'b1;
	int err_count = 0;
	int comparisons = 0;
	int cycles = 0;
	logic valid, wr, bt, idx, page_f, shared, resv, refused, hit, xbit, rvalid;
	spd_kind_t kind;
	spd_target_t target;
	logic [7:0] addr, wdata, r0, r1, rdata, page;
	logic [15:0] dptr, raddr;
	always #2 clk = ~clk;
	spd_core_model u_core (.clk(clk), .valid(valid), .kind(kind), .wr(wr), .bt(bt), .addr(addr),
		.wdata(wdata), .idx(idx), .r0(r0), .r1(r1), .dptr(dptr));
	spd_sfr_decode u_dut (.CLK(clk), .RESET(reset), .REQ_VALID(valid), .REQ_KIND(kind),
		.REQ_WRITE(wr), .REQ_BIT(bt), .REQ_BIT_POS(3'h0), .REQ_ADDR(addr), .REQ_WDATA(wdata),
		.REQ_IDX_SEL(idx), .REQ_R0(r0), .REQ_R1(r1), .REQ_DPTR(dptr), .RSP_VALID(rvalid),
		.RSP_TARGET(target), .RSP_ADDR(raddr), .RSP_PAGE_F(page_f), .RSP_SHARED(shared),
		.RSP_RESERVED(resv), .RSP_BIT_REFUSED(refused), .RSP_LOCAL(hit), .RSP_RDATA(rdata),
		.SFR_PAGE(page), .XRAM_PAGE_BIT(xbit));
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		comparisons++;
		if (got !== exp) begin
			$display("BAD %0t got %h exp %h", $time, got, exp);
			err_count++;
		end
	endtask
	task automatic t_paging();
		chk({page, xbit}, 9'h000);
		u_core.issue(SPD_KIND_DIRECT, 1'b1, 1'b0, 8'hA7, 8'h0F);
		chk({hit, shared, page}, 10'h30F);
		u_core.issue(SPD_KIND_DIRECT, 1'b0, 1'b0, 8'hBA, 8'h00);
		chk({page_f, shared, resv, target}, {3'b100, SPD_TGT_SFR});
		u_core.issue(SPD_KIND_DIRECT, 1'b0, 1'b0, 8'hA7, 8'h00);
		chk({page_f, shared, hit, rdata}, 11'h70F);
		u_core.issue(SPD_KIND_DIRECT, 1'b1, 1'b0, 8'hAA, 8'h01);
		chk({hit, xbit}, 2'h0);
		u_core.issue(SPD_KIND_DIRECT, 1'b1, 1'b0, 8'hA7, 8'h00);
		u_core.issue(SPD_KIND_DIRECT, 1'b0, 1'b0, 8'hBA, 8'h00);
		chk({page_f, page}, 9'h000);
		u_core.stop();
	endtask
	task automatic t_xpage();
		u_core.issue(SPD_KIND_DIRECT, 1'b1, 1'b0, 8'hAA, 8'hFF);
		chk({hit, xbit}, 2'h3);
		u_core.issue(SPD_KIND_DIRECT, 1'b0, 1'b0, 8'hAA, 8'h00);
		chk(rdata, 8'h01);
		u_core.issue(SPD_KIND_DIRECT, 1'b1, 1'b1, 8'hAA, 8'h00);
		chk({refused, xbit}, 2'h3);
		u_core.stop();
	endtask
	task automatic t_movx();
		for (int p = 0; p < 2; p++) begin
			u_core.issue(SPD_KIND_DIRECT, 1'b1, 1'b0, 8'hAA, {7'h55, p[0]});
			for (int i = 0; i < 2; i++) begin
				u_core.regs(i[0], 8'h34, 8'hC5);
				u_core.issue(SPD_KIND_MOVX8, 1'b0, 1'b0, 8'h00, 8'h00);
				chk({target, raddr}, {SPD_TGT_XRAM, 7'h00, p[0], (i ? 8'hC5 : 8'h34)});
				u_core.issue(SPD_KIND_MOVX16, 1'b1, 1'b0, 8'h00, 8'h00);
				chk({target, raddr}, {SPD_TGT_XRAM, 16'h1234});
			end
		end
		u_core.stop();
	endtask
	task automatic t_space();
		u_core.issue(SPD_KIND_INDIRECT, 1'b0, 1'b0, 8'hA7, 8'h00);
		chk({rvalid, target, raddr}, {1'b1, SPD_TGT_IRAM, 16'h00A7});
		u_core.issue(SPD_KIND_DIRECT, 1'b0, 1'b0, 8'h7F, 8'h00);
		chk({target, raddr}, {SPD_TGT_IRAM, 16'h007F});
		for (int n = 0; n < 16; n++) begin
			u_core.issue(SPD_KIND_DIRECT, 1'b0, 1'b1, {4'hE, n[3:0]}, 8'h00);
			chk({target, refused}, {SPD_TGT_SFR, n[2:0] != 3'h0});
		end
		u_core.stop();
		chk({rvalid, target, raddr}, {1'b0, SPD_TGT_NONE, 16'h0000});
	endtask
	task automatic end_sim();
		if (err_count == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 2000) begin
			err_count++;
			end_sim();
		end
	end
	initial begin
		repeat (5) @(posedge clk);
		@(negedge clk);
		reset = 1'b0;
		@(negedge clk);
		t_paging();
		t_xpage();
		t_movx();
		t_space();
		end_sim();
	end
endmodule
`default_nettype wire
